// [rtl/fiwc_flash_iap_ctrl.sv]
// Self-writable flash pages with byte program, page erase and timeout escape.
// Assumes the CPU core drives single-cycle SFR and external-data strobes on
// the same clock, and that it stalls while o_cpu_wait is high.
//
// Summary of operation
// - External-data write into 7A00h..7DFEh programs the accumulator byte there.
// - Commands act only while unlock and key registers hold valid codes.
// - Byte program occupies about 20 us before completing.
// - Page erase occupies about 2 ms before completing.
// - CPU waits during an operation; other peripherals keep running.
// - A built-in timeout ends a stuck operation and releases the CPU.
// - Unlock 65h, key BAh, write to 7B2Dh erases page 7A00h..7BFFh.
// - Unlock 65h, key BCh, write to 7D69h erases page 7C00h..7DFFh.
// - Every bit of an erased page reads back as one.
// - Key 4Ah permits one byte program within 7A00h..7BFFh.
// - Key 4Ch permits one byte program within 7C00h..7DFEh.
// - Any other key value disables program and erase.
// - Unlock 65h enables flash writing; any other value disables it.
// - Unlock register bit 0 reads whether the pages are writable.
// - With low-code lock at 0, reads and writes of 0000h..01FFh are blocked.
// - Key register bit 7 reads one while program or erase is enabled.
// - Timeout flag in key bit 6 sets on timeout, clears when disabled.
// - Timeout select 00 off; 01, 10, 11 give 0.8, 3.2, 6.4 ms.
module fiwc_flash_iap_ctrl #(
  parameter int PAGE_ERASE_CYCLES = fiwc_pkg::PAGE_ERASE_CYCLES,
  parameter int TIMEOUT_SHORT_CYCLES = fiwc_pkg::TIMEOUT_SHORT_CYCLES,
  parameter int TIMEOUT_MID_CYCLES = fiwc_pkg::TIMEOUT_MID_CYCLES,
  parameter int TIMEOUT_LONG_CYCLES = fiwc_pkg::TIMEOUT_LONG_CYCLES
) (
  input wire logic i_core_clk, // System clock
  input wire logic i_arst_n, // Power-on reset, active low
  input wire logic i_sfr_wr, // SFR write strobe
  input wire logic i_sfr_rd, // SFR read strobe
  input wire logic [7:0] i_sfr_addr, // SFR address
  input wire logic [7:0] i_sfr_wdata, // SFR write data
  input wire logic i_xdata_wr, // External-data write strobe
  input wire logic i_xdata_rd, // External-data read strobe
  input wire logic [15:0] i_xdata_addr, // Pointer register value
  input wire logic [7:0] i_xdata_wdata, // Accumulator value
  input wire logic i_code_rd, // Code-read strobe
  input wire logic [15:0] i_code_addr, // Code-read address
  input wire logic i_low_code_read_lock_n, // Configuration bit, 0 locks low code
  input wire logic [1:0] i_flash_timeout_select, // Timeout select field
  output logic [7:0] o_sfr_rdata, // SFR read data
  output logic o_cpu_wait, // Holds the CPU in a wait state
  output logic [7:0] o_code_rdata, // Code-read data
  output logic o_code_hit, // Code read addressed a self-writable page
  output logic o_access_blocked // Read or write of locked low code refused
);

  localparam int CW = 20;
  localparam int AW = 10;

  typedef struct packed {
    fiwc_pkg::fiwc_state_t st;
    logic [7:0] unlock;
    logic [7:0] key;
    logic timeout_flag;
    logic timeout_status;
    logic [CW-1:0] cnt;
    logic [CW-1:0] limit;
    logic [CW-1:0] tlimit;
    logic erase;
    logic [AW-1:0] addr;
    logic [7:0] data;
    logic [AW-1:0] eidx;
    logic edone;
    logic [7:0] sfr_rdata;
    logic cpu_wait;
    logic code_hit;
    logic blocked;
  } fiwc_regs_t;

  fiwc_regs_t r_q;
  fiwc_regs_t r_d;

  // Flash cells are not cleared by reset
  logic [7:0] flash_mem [0:(1<<AW)-1];
  logic [7:0] code_rdata_q;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic unlocked;
  logic key_write_lo;
  logic key_write_hi;
  logic key_erase_lo;
  logic key_erase_hi;
  logic write_enabled;
  logic in_write_range;
  logic in_upper_page;
  logic start_program;
  logic start_erase;
  logic code_in_area;
  logic code_low;
  logic xdata_low;
  logic [AW-1:0] xdata_offset;
  logic [AW-1:0] code_offset;
  logic op_done;
  logic op_timeout;
  logic enable_after_write;

  always_comb
  begin
    unlocked = (r_q.unlock == fiwc_pkg::UNLOCK_CODE);
    key_write_lo = (r_q.key == fiwc_pkg::KEY_WRITE_LO);
    key_write_hi = (r_q.key == fiwc_pkg::KEY_WRITE_HI);
    key_erase_lo = (r_q.key == fiwc_pkg::KEY_ERASE_LO);
    key_erase_hi = (r_q.key == fiwc_pkg::KEY_ERASE_HI);
    // Any other code leaves every path closed
    write_enabled = unlocked &&
      (key_write_lo || key_write_hi || key_erase_lo || key_erase_hi);
    in_write_range = (i_xdata_addr >= fiwc_pkg::SELF_WRITE_BASE) &&
      (i_xdata_addr <= fiwc_pkg::SELF_WRITE_LAST);
    in_upper_page = (i_xdata_addr >= fiwc_pkg::UPPER_PAGE_BASE);
    xdata_offset = AW'(i_xdata_addr - fiwc_pkg::SELF_WRITE_BASE);
    code_offset = AW'(i_code_addr - fiwc_pkg::SELF_WRITE_BASE);
    start_program = 1'b0;
    start_erase = 1'b0;
    if (i_xdata_wr && (r_q.st == fiwc_pkg::FIWC_IDLE) && unlocked)
    begin
      // Address must sit in the page that the key opened
      start_program = in_write_range &&
        ((key_write_lo && !in_upper_page) ||
         (key_write_hi && in_upper_page));
      start_erase =
        (key_erase_lo && (i_xdata_addr == fiwc_pkg::ERASE_TRIGGER_LO)) ||
        (key_erase_hi && (i_xdata_addr == fiwc_pkg::ERASE_TRIGGER_HI));
    end
    code_in_area = (i_code_addr >= fiwc_pkg::SELF_WRITE_BASE) &&
      (i_code_addr <= fiwc_pkg::SELF_AREA_LAST);
    code_low = (i_code_addr <= fiwc_pkg::LOW_CODE_LAST);
    xdata_low = (i_xdata_addr <= fiwc_pkg::LOW_CODE_LAST);
    op_done = (r_q.cnt == r_q.limit);
    op_timeout = (r_q.tlimit != '0) && (r_q.cnt == r_q.tlimit);
  end

  // ----------------------------------------------------------------
  // Timeout limit per select code
  // ----------------------------------------------------------------
  logic [CW-1:0] tsel_limit;

  always_comb
  begin
    case (i_flash_timeout_select)
      fiwc_pkg::TIMEOUT_OFF: tsel_limit = '0;
      fiwc_pkg::TIMEOUT_SHORT: tsel_limit = CW'(TIMEOUT_SHORT_CYCLES - 1);
      fiwc_pkg::TIMEOUT_MID: tsel_limit = CW'(TIMEOUT_MID_CYCLES - 1);
      default: tsel_limit = CW'(TIMEOUT_LONG_CYCLES - 1);
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.code_hit = 1'b0;
    r_d.blocked = 1'b0;
    mem_we = 1'b0;
    mem_waddr = r_q.addr;
    mem_wdata = r_q.data;

    // Register writes; the CPU is stalled while busy
    if (i_sfr_wr && (i_sfr_addr == fiwc_pkg::UNLOCK_CMD_ADDR))
    begin
      r_d.unlock = i_sfr_wdata;
    end
    if (i_sfr_wr && (i_sfr_addr == fiwc_pkg::WRITE_KEY_ADDR))
    begin
      r_d.key = i_sfr_wdata;
    end

    // Register reads
    if (i_sfr_rd)
    begin
      r_d.sfr_rdata = '0;
      if (i_sfr_addr == fiwc_pkg::UNLOCK_CMD_ADDR)
      begin
        r_d.sfr_rdata[fiwc_pkg::SECTOR_ACCESS_BIT] = unlocked;
        r_d.sfr_rdata[fiwc_pkg::WRITE_TIMEOUT_STATUS_BIT] = r_q.timeout_status;
      end
      else if (i_sfr_addr == fiwc_pkg::WRITE_KEY_ADDR)
      begin
        r_d.sfr_rdata[fiwc_pkg::WRITE_ENABLE_BIT] = write_enabled;
        r_d.sfr_rdata[fiwc_pkg::TIMEOUT_FLAG_BIT] = r_q.timeout_flag;
      end
    end

    // Flags clear in the edge of the write that closes the path, so a read
    // right behind that write never shows a stale flag
    enable_after_write = (r_d.unlock == fiwc_pkg::UNLOCK_CODE) &&
      ((r_d.key == fiwc_pkg::KEY_WRITE_LO) || (r_d.key == fiwc_pkg::KEY_WRITE_HI) ||
       (r_d.key == fiwc_pkg::KEY_ERASE_LO) || (r_d.key == fiwc_pkg::KEY_ERASE_HI));
    if (!enable_after_write)
    begin
      r_d.timeout_flag = 1'b0;
    end
    if (r_d.unlock != fiwc_pkg::UNLOCK_CODE)
    begin
      r_d.timeout_status = 1'b0;
    end

    // Locked low code area
    if ((i_code_rd && code_low) || ((i_xdata_wr || i_xdata_rd) && xdata_low))
    begin
      r_d.blocked = !i_low_code_read_lock_n;
    end
    if (i_code_rd)
    begin
      r_d.code_hit = code_in_area;
    end

    case (r_q.st)
      fiwc_pkg::FIWC_IDLE:
      begin
        r_d.cnt = '0;
        if (start_program || start_erase)
        begin
          r_d.st = fiwc_pkg::FIWC_BUSY;
          r_d.cpu_wait = 1'b1;
          r_d.erase = start_erase;
          r_d.addr = xdata_offset;
          r_d.data = i_xdata_wdata;
          r_d.eidx = {in_upper_page, {(AW-1){1'b0}}};
          r_d.edone = 1'b0;
          r_d.limit = start_erase ? CW'(PAGE_ERASE_CYCLES - 1) :
            CW'(fiwc_pkg::BYTE_PROGRAM_CYCLES - 1);
          r_d.tlimit = tsel_limit;
        end
      end
      fiwc_pkg::FIWC_BUSY:
      begin
        r_d.cnt = r_q.cnt + CW'(1);
        // Erase clears one byte per cycle across the page
        if (r_q.erase && !r_q.edone)
        begin
          mem_we = 1'b1;
          mem_waddr = r_q.eidx;
          mem_wdata = fiwc_pkg::ERASED_BYTE;
          r_d.eidx = r_q.eidx + AW'(1);
          r_d.edone = (r_q.eidx[AW-2:0] == {(AW-1){1'b1}});
        end
        if (op_timeout && !op_done)
        begin
          // Escape a stuck operation; byte is not committed
          r_d.st = fiwc_pkg::FIWC_IDLE;
          r_d.cpu_wait = 1'b0;
          r_d.timeout_flag = 1'b1;
          r_d.timeout_status = 1'b1;
        end
        else if (op_done)
        begin
          r_d.st = fiwc_pkg::FIWC_IDLE;
          r_d.cpu_wait = 1'b0;
          if (!r_q.erase)
          begin
            // Programming can only clear bits of the stored byte
            mem_we = 1'b1;
            mem_waddr = r_q.addr;
            mem_wdata = flash_mem[r_q.addr] & r_q.data;
          end
        end
      end
      default:
      begin
        r_d.st = fiwc_pkg::FIWC_IDLE;
        r_d.cpu_wait = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      r_q.st <= fiwc_pkg::FIWC_IDLE;
      r_q.unlock <= fiwc_pkg::UNLOCK_CMD_RESET;
      r_q.key <= fiwc_pkg::WRITE_KEY_RESET;
      r_q.timeout_flag <= 1'b0;
      r_q.timeout_status <= 1'b0;
      r_q.cnt <= '0;
      r_q.limit <= '0;
      r_q.tlimit <= '0;
      r_q.erase <= 1'b0;
      r_q.addr <= '0;
      r_q.data <= '0;
      r_q.eidx <= '0;
      r_q.edone <= 1'b0;
      r_q.sfr_rdata <= '0;
      r_q.cpu_wait <= 1'b0;
      r_q.code_hit <= 1'b0;
      r_q.blocked <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Flash array
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (mem_we)
    begin
      flash_mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      code_rdata_q <= fiwc_pkg::ERASED_BYTE;
    end
    else if (i_code_rd)
    begin
      code_rdata_q <= code_in_area ? flash_mem[code_offset] :
        fiwc_pkg::ERASED_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sfr_rdata = r_q.sfr_rdata;
  assign o_cpu_wait = r_q.cpu_wait;
  assign o_code_rdata = code_rdata_q;
  assign o_code_hit = r_q.code_hit;
  assign o_access_blocked = r_q.blocked;

endmodule

// [rtl/fiwc_pkg.sv]
// Constants shared by the flash write/erase sequencer.
// Assumes a 50 MHz system clock and an 8051-style special-function bus.
package fiwc_pkg;

  // ----------------------------------------------------------------
  // Special-function register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_CMD_ADDR = 8'h97;
  localparam logic [7:0] WRITE_KEY_ADDR = 8'hC9;

  // ----------------------------------------------------------------
  // Key codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_CODE = 8'h65;
  localparam logic [7:0] KEY_WRITE_LO = 8'h4A;
  localparam logic [7:0] KEY_WRITE_HI = 8'h4C;
  localparam logic [7:0] KEY_ERASE_LO = 8'hBA;
  localparam logic [7:0] KEY_ERASE_HI = 8'hBC;
  localparam logic [7:0] UNLOCK_CMD_RESET = 8'h00;
  localparam logic [7:0] WRITE_KEY_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SECTOR_ACCESS_BIT = 0;
  localparam int WRITE_TIMEOUT_STATUS_BIT = 1;
  localparam int TIMEOUT_FLAG_BIT = 6;
  localparam int WRITE_ENABLE_BIT = 7;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] SELF_WRITE_BASE = 16'h7A00;
  localparam logic [15:0] SELF_WRITE_LAST = 16'h7DFE;
  localparam logic [15:0] UPPER_PAGE_BASE = 16'h7C00;
  localparam logic [15:0] SELF_AREA_LAST = 16'h7DFF;
  localparam logic [15:0] ERASE_TRIGGER_LO = 16'h7B2D;
  localparam logic [15:0] ERASE_TRIGGER_HI = 16'h7D69;
  localparam logic [15:0] LOW_CODE_LAST = 16'h01FF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int BYTE_PROGRAM_TIME_NS = 20000;
  localparam int PAGE_ERASE_TIME_US = 2000;
  localparam int TIMEOUT_SHORT_US = 800;
  localparam int TIMEOUT_MID_US = 3200;
  localparam int TIMEOUT_LONG_US = 6400;
  localparam int BYTE_PROGRAM_CYCLES = BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_SHORT_CYCLES = TIMEOUT_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_MID_CYCLES = TIMEOUT_MID_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_LONG_CYCLES = TIMEOUT_LONG_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Timeout select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TIMEOUT_OFF = 2'h0;
  localparam logic [1:0] TIMEOUT_SHORT = 2'h1;
  localparam logic [1:0] TIMEOUT_MID = 2'h2;

  typedef enum logic [0:0] {FIWC_IDLE, FIWC_BUSY} fiwc_state_t;

endpackage

// [verif/fiwc_cpu_model.sv]
// Behavioural CPU core issuing SFR, MOVX and MOVC cycles.
// Assumes strobes are taken on the rising edge; it drives on the falling edge.
module fiwc_cpu_model (
  input wire logic i_core_clk, // Clock
  input wire logic i_cpu_wait, // Stall request
  input wire logic [7:0] i_sfr_rdata, // SFR read data
  input wire logic [7:0] i_code_rdata, // Code data
  output logic o_sfr_wr = 1'b0, // SFR write
  output logic o_sfr_rd = 1'b0, // SFR read
  output logic [7:0] o_sfr_addr = 8'h00, // SFR address
  output logic [7:0] o_sfr_wdata = 8'h00, // SFR data
  output logic o_xdata_wr = 1'b0, // MOVX write
  output logic o_xdata_rd = 1'b0, // MOVX read
  output logic [15:0] o_xdata_addr = 16'h0000, // Pointer
  output logic [7:0] o_xdata_wdata = 8'h00, // Accumulator
  output logic o_code_rd = 1'b0, // MOVC read
  output logic [15:0] o_code_addr = 16'h0000 // MOVC address
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_sfr_addr = a;
    o_sfr_wdata = d;
    o_sfr_wr = 1'b1;
    @(negedge i_core_clk);
    o_sfr_wr = 1'b0;
    o_sfr_wdata = ~d;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_sfr_addr = a;
    o_sfr_rd = 1'b1;
    @(negedge i_core_clk);
    o_sfr_rd = 1'b0;
    d = i_sfr_rdata;
  endtask
  task automatic code_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_code_addr = a;
    o_code_rd = 1'b1;
    @(negedge i_core_clk);
    o_code_rd = 1'b0;
    d = i_code_rdata;
  endtask
  task automatic xdata_rd(input logic [15:0] a);
    @(negedge i_core_clk);
    o_xdata_addr = a;
    o_xdata_rd = 1'b1;
    @(negedge i_core_clk);
    o_xdata_rd = 1'b0;
  endtask
  // Pointer holds the target, accumulator the byte; returns stall cycles
  task automatic xdata_wr(input logic [15:0] a, input logic [7:0] d, output int n);
    @(negedge i_core_clk);
    o_xdata_addr = a;
    o_xdata_wdata = d;
    o_xdata_wr = 1'b1;
    @(negedge i_core_clk);
    o_xdata_wr = 1'b0;
    o_xdata_wdata = ~d;
    n = 0;
    // Core stays frozen for up to 5000 stalled cycles and resumes with nothing pending
    while (i_cpu_wait === 1'b1 && n < 5000)
    begin
      @(negedge i_core_clk);
      n++;
    end
  endtask
endmodule

// [verif/fiwc_flash_iap_ctrl_props.sv]
// Port checker for the flash write/erase sequencer.
// Assumes the key registers change only through the SFR write strobe.
module fiwc_props #(
  parameter int PAGE_ERASE_CYCLES = 600,
  parameter int TIMEOUT_SHORT_CYCLES = 300,
  parameter int TIMEOUT_MID_CYCLES = 1200,
  parameter int TIMEOUT_LONG_CYCLES = 2400
) (
  input wire logic i_core_clk, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic i_sfr_wr, // SFR write
  input wire logic i_sfr_rd, // SFR read
  input wire logic [7:0] i_sfr_addr, // SFR address
  input wire logic [7:0] i_sfr_wdata, // SFR data
  input wire logic i_xdata_wr, // MOVX write
  input wire logic i_xdata_rd, // MOVX read
  input wire logic [15:0] i_xdata_addr, // Pointer
  input wire logic [7:0] i_xdata_wdata, // Accumulator
  input wire logic i_code_rd, // MOVC read
  input wire logic [15:0] i_code_addr, // MOVC address
  input wire logic i_low_code_read_lock_n, // Lock
  input wire logic [1:0] i_flash_timeout_select, // Timeout select
  input wire logic [7:0] o_sfr_rdata, // SFR read data
  input wire logic o_cpu_wait, // Stall
  input wire logic [7:0] o_code_rdata, // Code data
  input wire logic o_code_hit, // Code hit
  input wire logic o_access_blocked // Lock refusal
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Shadow keys and expected stall length
  // ------
  logic [7:0] unl_q;
  logic [7:0] key_q;
  logic prog, legal, take, en;
  int cnt_q, exp_q, lim, t;
  assign en = unl_q == 8'h65 && key_q inside {8'h4A, 8'h4C, 8'hBA, 8'hBC};
  assign prog = (key_q == 8'h4A && i_xdata_addr inside {[16'h7A00:16'h7BFF]})
    || (key_q == 8'h4C && i_xdata_addr inside {[16'h7C00:16'h7DFE]});
  assign legal = unl_q == 8'h65 && (prog || (key_q == 8'hBA && i_xdata_addr == 16'h7B2D)
    || (key_q == 8'hBC && i_xdata_addr == 16'h7D69));
  assign take = i_xdata_wr && !o_cpu_wait && legal;
  always_comb
  begin
    t = TIMEOUT_LONG_CYCLES;
    if (i_flash_timeout_select == 2'h1)
      t = TIMEOUT_SHORT_CYCLES;
    if (i_flash_timeout_select == 2'h2)
      t = TIMEOUT_MID_CYCLES;
    lim = prog ? 1000 : PAGE_ERASE_CYCLES;
    if (i_flash_timeout_select != 2'h0 && t < lim)
      lim = t;
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      unl_q <= 8'h00;
      key_q <= 8'h00;
      cnt_q <= 0;
      exp_q <= 0;
    end
    else
    begin
      if (i_sfr_wr && i_sfr_addr == 8'h97)
        unl_q <= i_sfr_wdata;
      if (i_sfr_wr && i_sfr_addr == 8'hC9)
        key_q <= i_sfr_wdata;
      cnt_q <= o_cpu_wait ? cnt_q + 1 : 0;
      if (take)
        exp_q <= lim;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  AST_NO_TAKE: assert property (i_xdata_wr && !o_cpu_wait && !legal
    |=> !o_cpu_wait)
    else $error("stall without a valid command");
  AST_TAKE: assert property (take |=> o_cpu_wait)
    else $error("valid command did not stall");
  AST_CAUSE: assert property ($rose(o_cpu_wait) |-> $past(take))
    else $error("stall rose with no command");
  AST_LEN: assert property ($fell(o_cpu_wait) |-> cnt_q == exp_q)
    else $error("stall length wrong");
  AST_SECTOR: assert property (i_sfr_rd && i_sfr_addr == 8'h97
    |=> o_sfr_rdata[0] == $past(unl_q == 8'h65))
    else $error("sector access flag wrong");
  AST_ENABLE: assert property (i_sfr_rd && i_sfr_addr == 8'hC9
    |=> o_sfr_rdata[7] == $past(en))
    else $error("enable bit wrong");
  AST_TOFLAG: assert property (i_sfr_rd && i_sfr_addr == 8'hC9 && !en
    |=> o_sfr_rdata == 8'h00)
    else $error("timeout flag kept while disabled");
  AST_LOCK: assert property (i_code_rd && !i_low_code_read_lock_n
    && i_code_addr <= 16'h01FF |=> o_access_blocked)
    else $error("locked low code not refused");
  AST_XLOCK: assert property ((i_xdata_rd || i_xdata_wr) && !i_low_code_read_lock_n
    && i_xdata_addr <= 16'h01FF |=> o_access_blocked)
    else $error("locked low data not refused");
  AST_HIT: assert property (i_code_rd
    |=> o_code_hit == $past(i_code_addr inside {[16'h7A00:16'h7DFF]}))
    else $error("code hit wrong");
endmodule

bind fiwc_flash_iap_ctrl fiwc_props #(
  .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES), .TIMEOUT_SHORT_CYCLES(TIMEOUT_SHORT_CYCLES),
  .TIMEOUT_MID_CYCLES(TIMEOUT_MID_CYCLES), .TIMEOUT_LONG_CYCLES(TIMEOUT_LONG_CYCLES)
) i_fiwc_props (.i_core_clk, .i_arst_n, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata,
  .i_xdata_wr, .i_xdata_rd, .i_xdata_addr, .i_xdata_wdata, .i_code_rd, .i_code_addr,
  .i_low_code_read_lock_n, .i_flash_timeout_select, .o_sfr_rdata, .o_cpu_wait,
  .o_code_rdata, .o_code_hit, .o_access_blocked);

// [verif/fiwc_flash_iap_ctrl_test.sv]
// Self-checking bench for the flash write/erase sequencer.
// Assumes the CPU model drives every bus strobe on the falling clock edge.
module fiwc_flash_iap_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic lock_n = 1'b1;
  logic [1:0] tsel = 2'h0;
  logic s_wr, s_rd, x_wr, x_rd, c_rd, wait_o, hit, blocked;
  logic [7:0] s_addr, s_wd, x_wd, s_rdata, c_rdata, d;
  logic [15:0] x_addr, c_addr, a16;
  logic [7:0] keys [6] = '{8'h4A, 8'h4C, 8'hBA, 8'hBC, 8'h4B, 8'h00};
  logic [15:0] eaddr [5] = '{16'h7A00, 16'h7B2D, 16'h7BFF, 16'h7C00, 16'h7DFF};
  int num_errors = 0;
  int total_checks = 0;
  int n;
  always #10 clk = ~clk;
  fiwc_flash_iap_ctrl #(.PAGE_ERASE_CYCLES(600), .TIMEOUT_SHORT_CYCLES(300),
    .TIMEOUT_MID_CYCLES(1200), .TIMEOUT_LONG_CYCLES(2400)) i_fiwc_flash_iap_ctrl (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_sfr_wr(s_wr), .i_sfr_rd(s_rd),
    .i_sfr_addr(s_addr), .i_sfr_wdata(s_wd), .i_xdata_wr(x_wr), .i_xdata_rd(x_rd),
    .i_xdata_addr(x_addr), .i_xdata_wdata(x_wd), .i_code_rd(c_rd), .i_code_addr(c_addr),
    .i_low_code_read_lock_n(lock_n), .i_flash_timeout_select(tsel), .o_sfr_rdata(s_rdata),
    .o_cpu_wait(wait_o), .o_code_rdata(c_rdata), .o_code_hit(hit), .o_access_blocked(blocked));
  fiwc_cpu_model i_fiwc_cpu_model (.i_core_clk(clk), .i_cpu_wait(wait_o),
    .i_sfr_rdata(s_rdata), .i_code_rdata(c_rdata), .o_sfr_wr(s_wr), .o_sfr_rd(s_rd),
    .o_sfr_addr(s_addr), .o_sfr_wdata(s_wd), .o_xdata_wr(x_wr), .o_xdata_rd(x_rd),
    .o_xdata_addr(x_addr), .o_xdata_wdata(x_wd), .o_code_rd(c_rd), .o_code_addr(c_addr));
  // ------
  // Compare and access tasks
  // ------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_fiwc_cpu_model.sfr_wr(a, v);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    i_fiwc_cpu_model.sfr_rd(a, d);
    chk8(d, e, "sfr read");
  endtask
  task automatic rcode(input logic [15:0] a, input logic [7:0] e);
    i_fiwc_cpu_model.code_rd(a, d);
    chk8(d, e, "code read");
  endtask
  task automatic op(input logic [7:0] k, input logic [15:0] a, input logic [7:0] v, input int e);
    wr(8'h97, 8'h65);
    wr(8'hC9, k);
    i_fiwc_cpu_model.xdata_wr(a, v, n);
    chkn(n, e, "stall cycles");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #(20 * 30000);
    num_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    final_report;
  end
  // ------
  // Tests
  // ------
  initial
  begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    rreg(8'h97, 8'h00);
    rreg(8'hC9, 8'h00);
    rreg(8'h55, 8'h00);
    wr(8'h97, 8'h65);
    rreg(8'h97, 8'h01);
    foreach (keys[i])
    begin
      wr(8'hC9, keys[i]);
      rreg(8'hC9, i < 4 ? 8'h80 : 8'h00);
    end
    wr(8'h97, 8'h12);
    wr(8'hC9, 8'h4A);
    rreg(8'hC9, 8'h00);
    i_fiwc_cpu_model.xdata_wr(16'h7A01, 8'h00, n);
    chkn(n, 0, "locked write");
    $display("test registers done");
    op(8'hBA, 16'h7A00, 8'h00, 0);
    tsel = 2'h2;
    op(8'hBA, 16'h7B2D, 8'h33, 600);
    rreg(8'hC9, 8'h80);
    tsel = 2'h0;
    op(8'hBC, 16'h7D69, 8'h00, 600);
    foreach (eaddr[i])
      rcode(eaddr[i], 8'hFF);
    $display("test erase done");
    // Low-voltage reset is taken as off around writes
    op(8'h4A, 16'h7A00, 8'h5A, 1000);
    i_fiwc_cpu_model.xdata_wr(16'h7C00, 8'h11, n);
    chkn(n, 0, "wrong page");
    op(8'h4C, 16'h7DFF, 8'h00, 0);
    op(8'h4C, 16'h7DFE, 8'hA5, 1000);
    wr(8'hC9, 8'h00);
    wr(8'h97, 8'h00);
    rcode(16'h7A00, 8'h5A);
    rcode(16'h7C00, 8'hFF);
    rcode(16'h7DFE, 8'hA5);
    $display("test program done");
    for (int s = 1; s < 4; s++)
    begin
      tsel = 2'(s);
      a16 = 16'h7A10 + 16'(s);
      op(8'h4A, a16, 8'h0F, s == 1 ? 300 : 1000);
      rreg(8'hC9, s == 1 ? 8'hC0 : 8'h80);
      rreg(8'h97, s == 1 ? 8'h03 : 8'h01);
      rcode(a16, s == 1 ? 8'hFF : 8'h0F);
      wr(8'hC9, 8'h00);
      rreg(8'hC9, 8'h00);
      wr(8'h97, 8'h00);
      rreg(8'h97, 8'h00);
    end
    $display("test timeout done");
    lock_n = 1'b0;
    i_fiwc_cpu_model.code_rd(16'h01FF, d);
    chk8({7'h00, blocked}, 8'h01, "low code lock");
    i_fiwc_cpu_model.code_rd(16'h0200, d);
    chk8({7'h00, blocked}, 8'h00, "above lock");
    i_fiwc_cpu_model.xdata_rd(16'h0000);
    chk8({7'h00, blocked}, 8'h01, "low data lock");
    $display("test lock done");
    final_report;
  end
endmodule
